// ===== src/rxm_map.svh
`ifndef RXM_MAP_SVH
`define RXM_MAP_SVH

// Clock and sample timing.
`define RXM_CLK_NS         10
`define RXM_TS_NS          1600
`define RXM_TS_CYC         (`RXM_TS_NS / `RXM_CLK_NS)
`define RXM_HOLD_TICKS     2'd2

// Identifier send rate.
`define RXM_CLK_HZ         100000000
`define RXM_ID_BAUD        310000
`define RXM_BIT_CYC        (`RXM_CLK_HZ / `RXM_ID_BAUD)

// Wake and time-out counts in strobe periods, and the dummy byte.
`define RXM_RATIO_0        5'd3
`define RXM_RATIO_1        5'd7
`define RXM_RATIO_2        5'd15
`define RXM_RATIO_3        5'd31
`define RXM_TIMEOUT        7'd66
`define RXM_DUMMY_BYTE     8'h00

// Configuration word: register 1 in [23:16], 2 in [15:8], 3 in [7:0].
`define RXM_CFG_RESET      24'hd40080
`define RXM_CFG_READ_BIT   23
`define RXM_CFG_SOE_BIT    20
`define RXM_CFG_SR_HI      19
`define RXM_CFG_SR_LO      18
`define RXM_CFG_DME_BIT    17
`define RXM_CFG_HE_BIT     16
`define RXM_CFG_ID_HI      15
`define RXM_CFG_ID_LO      8

`endif

// ===== src/rxm_pkg.sv
package rxm_pkg;

   typedef enum logic [3:0] {
      ST_POR       = 4'h0,
      ST_CONFIG    = 4'h1,
      ST_SLEEP_ENT = 4'h3,
      ST_OSC_SLEEP = 4'h2,
      ST_OSC_RUN   = 4'h6,
      ST_OSC_HDR   = 4'h7,
      ST_OSC_DATA  = 4'h5,
      ST_OSC_DUMMY = 4'h4,
      ST_PIN_SLEEP = 4'hc,
      ST_PIN_RUN   = 4'hd,
      ST_PIN_ID    = 4'hf,
      ST_PIN_HDR   = 4'he,
      ST_PIN_DATA  = 4'ha,
      ST_PIN_RAW   = 4'hb,
      ST_PIN_DRAIN = 4'h9
   } rxm_state_e;

   typedef struct packed {
      rxm_state_e state;
      logic [7:0] tick_cnt;
      logic [1:0] hold_cnt;
      logic [23:0] cfg;
      logic [4:0] wake_cnt;
      logic [6:0] tmo_cnt;
      logic       strobe_seen;
      logic       id_seen;
      logic       hdr_seen;
      logic       hdr_inv;
      logic       eom_seen;
      logic       invert;
      logic       byte_pending;
      logic       mosi;
      logic       mosi_oe;
      logic       sclk;
      logic       sclk_oe;
   } rxm_ctrl_s;

   typedef struct packed {
      logic       busy;
      logic [7:0] sr;
      logic [2:0] bit_cnt;
      logic [8:0] timer;
      logic       clk_en;
   } rxm_shift_s;

endpackage

// ===== src/rxm_shift_if.sv
`timescale 1ns/1ps
interface rxm_shift_if;
   logic       load;
   logic [7:0] din;
   logic       with_clock;
   logic       busy;
   logic       sdo;
   logic       sclk;

   modport ctrl (output load, output din, output with_clock,
                 input busy, input sdo, input sclk);
   modport shifter (input load, input din, input with_clock,
                    output busy, output sdo, output sclk);
endinterface

// ===== src/rxm_shift.sv
`timescale 1ns/1ps
`include "rxm_map.svh"

// Serialises one byte MSB first; the clock rises at the start of each bit.
module rxm_shift (
   // Clock and reset
   input  wire logic      clk,
   input  wire logic      rst,
   // Byte port
   rxm_shift_if.shifter   sif
);
   rxm_pkg::rxm_shift_s q;
   rxm_pkg::rxm_shift_s d;

   localparam logic [8:0] BIT_LAST  = 9'(`RXM_BIT_CYC - 1);
   localparam logic [8:0] BIT_HALF  = 9'(`RXM_BIT_CYC / 2);

   always_comb begin
      d = q;
      if (!q.busy) begin
         if (sif.load) begin
            d.busy    = 1'b1;
            d.sr      = sif.din;
            d.bit_cnt = 3'h0;
            d.timer   = 9'h000;
            d.clk_en  = sif.with_clock;
         end
      end else if (q.timer == BIT_LAST) begin
         d.timer   = 9'h000;
         d.sr      = {q.sr[6:0], 1'b0};
         d.bit_cnt = q.bit_cnt + 3'h1;
         if (q.bit_cnt == 3'h7) begin
            d.busy = 1'b0;
         end
      end else begin
         d.timer = q.timer + 9'h001;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign sif.busy = q.busy;
   assign sif.sdo  = q.busy & q.sr[7];
   assign sif.sclk = q.busy & q.clk_en & (q.timer < BIT_HALF);
endmodule

// ===== src/rxm_seq.sv
`timescale 1ns/1ps
`include "rxm_map.svh"

module rxm_seq (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Controller pins
   input  wire logic        config_hold_n,
   input  wire logic        strobe_pin,
   input  wire logic        strobe_at_supply,
   // Configuration write from the slave SPI
   input  wire logic        cfg_write,
   input  wire logic [23:0] cfg_data,
   // Strobe oscillator and data manager events
   input  wire logic        strobe_tick,
   input  wire logic        demod_raw,
   input  wire logic        match_found,
   input  wire logic        header_found,
   input  wire logic        header_inverted,
   input  wire logic        end_of_message,
   input  wire logic        data_valid,
   input  wire logic [7:0]  data_byte,
   // Mode and power outputs
   output logic [3:0]       state_code,
   output logic             receiver_on,
   output logic             strobe_osc_on,
   output logic             osc_pulldown_en,
   output logic             spi_slave_mode,
   output logic [23:0]      config_regs,
   output logic             demod_data_pin,
   // Master SPI pins
   output logic             mosi_o,
   output logic             mosi_oe,
   output logic             sclk_o,
   output logic             sclk_oe
);
   rxm_pkg::rxm_ctrl_s q;
   rxm_pkg::rxm_ctrl_s d;
   rxm_shift_if        sif ();

   localparam logic [7:0] TS_LAST = 8'(`RXM_TS_CYC - 1);

   logic       tick;
   logic       strobe_osc_enable;
   logic       data_manager_enable;
   logic       he_eff;
   logic       strobe_high;
   logic [4:0] ratio;
   logic       load;
   logic [7:0] load_byte;
   logic       leave;

   rxm_shift u_shift (
      .clk (clk),
      .rst (rst),
      .sif (sif)
   );

   always_comb begin
      strobe_osc_enable         = q.cfg[`RXM_CFG_SOE_BIT];
      data_manager_enable         = q.cfg[`RXM_CFG_DME_BIT];
      he_eff      = q.cfg[`RXM_CFG_HE_BIT] & data_manager_enable;
      strobe_high = strobe_pin | strobe_at_supply;
      tick        = (q.tick_cnt == TS_LAST);
      case (q.cfg[`RXM_CFG_SR_HI:`RXM_CFG_SR_LO])
         2'h0:    ratio = `RXM_RATIO_0;
         2'h1:    ratio = `RXM_RATIO_1;
         2'h2:    ratio = `RXM_RATIO_2;
         default: ratio = `RXM_RATIO_3;
      endcase
   end

   // Byte loads into the shifter: identifier, received data, or the dummy byte.
   always_comb begin
      load      = 1'b0;
      load_byte = `RXM_DUMMY_BYTE;
      case (q.state)
         rxm_pkg::ST_PIN_ID: begin
            load      = q.byte_pending & ~sif.busy;
            load_byte = q.cfg[`RXM_CFG_ID_HI:`RXM_CFG_ID_LO];
         end
         rxm_pkg::ST_OSC_DUMMY: begin
            load = q.byte_pending & ~sif.busy;
         end
         rxm_pkg::ST_OSC_DATA, rxm_pkg::ST_PIN_DATA: begin
            load      = data_valid & ~sif.busy;
            load_byte = data_byte ^ {8{q.invert}};
         end
         default: begin
            load = 1'b0;
         end
      endcase
   end

   assign sif.load       = load;
   assign sif.din        = load_byte;
   assign sif.with_clock = 1'b1;

   always_comb begin
      d          = q;
      d.tick_cnt = tick ? 8'h00 : q.tick_cnt + 8'h01;
      if (load) begin
         d.byte_pending = 1'b0;
      end

      // Event flags: a new event wins over the clear on state change.
      d.strobe_seen = q.strobe_seen | strobe_tick;
      d.id_seen     = q.id_seen | match_found;
      d.hdr_seen    = q.hdr_seen | header_found;
      d.hdr_inv     = q.hdr_inv | (header_found & header_inverted);
      d.eom_seen    = q.eom_seen | end_of_message;

      if (q.state == rxm_pkg::ST_OSC_SLEEP && strobe_tick && q.wake_cnt != ratio) begin
         d.wake_cnt = q.wake_cnt + 5'h01;
      end
      if (q.state == rxm_pkg::ST_OSC_HDR && strobe_tick && q.tmo_cnt != `RXM_TIMEOUT) begin
         d.tmo_cnt = q.tmo_cnt + 7'h01;
      end

      if (q.state == rxm_pkg::ST_CONFIG && cfg_write && !cfg_data[`RXM_CFG_READ_BIT]) begin
         d.cfg = cfg_data;
      end

      if (tick) begin
         d.hold_cnt = config_hold_n ? 2'h0 :
                      (q.hold_cnt == `RXM_HOLD_TICKS) ? q.hold_cnt : q.hold_cnt + 2'h1;
         if (!config_hold_n && q.hold_cnt == `RXM_HOLD_TICKS - 2'h1) begin
            d.state = rxm_pkg::ST_CONFIG;
         end else begin
            case (q.state)
               rxm_pkg::ST_POR: begin
                  d.state = config_hold_n ? rxm_pkg::ST_SLEEP_ENT : rxm_pkg::ST_CONFIG;
               end
               rxm_pkg::ST_CONFIG: begin
                  if (config_hold_n) begin
                     d.state = rxm_pkg::ST_SLEEP_ENT;
                  end
               end
               rxm_pkg::ST_SLEEP_ENT: begin
                  d.state = strobe_osc_enable ? rxm_pkg::ST_OSC_SLEEP : rxm_pkg::ST_PIN_SLEEP;
               end
               rxm_pkg::ST_OSC_SLEEP: begin
                  if (!strobe_osc_enable) begin
                     d.state = rxm_pkg::ST_PIN_SLEEP;
                  end else if (q.wake_cnt == ratio || strobe_high) begin
                     d.state = rxm_pkg::ST_OSC_RUN;
                  end
               end
               rxm_pkg::ST_OSC_RUN: begin
                  if (q.id_seen) begin
                     d.state = he_eff ? rxm_pkg::ST_OSC_HDR : rxm_pkg::ST_OSC_DATA;
                  end else if (q.strobe_seen && !strobe_high) begin
                     d.state = rxm_pkg::ST_SLEEP_ENT;
                  end
               end
               rxm_pkg::ST_OSC_HDR: begin
                  if (q.hdr_seen) begin
                     d.state = rxm_pkg::ST_OSC_DATA;
                  end else if (q.tmo_cnt == `RXM_TIMEOUT) begin
                     d.state = rxm_pkg::ST_SLEEP_ENT;
                  end
               end
               rxm_pkg::ST_OSC_DATA: begin
                  if (q.eom_seen && !sif.busy && !load) begin
                     d.state = rxm_pkg::ST_OSC_DUMMY;
                  end
               end
               rxm_pkg::ST_OSC_DUMMY: begin
                  if (!q.byte_pending && !sif.busy) begin
                     d.state = rxm_pkg::ST_SLEEP_ENT;
                  end
               end
               rxm_pkg::ST_PIN_SLEEP: begin
                  if (strobe_osc_enable) begin
                     d.state = rxm_pkg::ST_OSC_SLEEP;
                  end else if (strobe_high) begin
                     d.state = rxm_pkg::ST_PIN_RUN;
                  end
               end
               rxm_pkg::ST_PIN_RUN: begin
                  if (!strobe_high) begin
                     d.state = rxm_pkg::ST_SLEEP_ENT;
                  end else if (q.id_seen) begin
                     d.state = rxm_pkg::ST_PIN_ID;
                  end
               end
               rxm_pkg::ST_PIN_ID: begin
                  if (!strobe_high) begin
                     d.state = rxm_pkg::ST_SLEEP_ENT;
                  end else if (!q.byte_pending && !sif.busy) begin
                     d.state = he_eff ? rxm_pkg::ST_PIN_HDR : rxm_pkg::ST_PIN_DATA;
                  end
               end
               rxm_pkg::ST_PIN_HDR: begin
                  if (!strobe_high) begin
                     d.state = rxm_pkg::ST_SLEEP_ENT;
                  end else if (q.hdr_seen) begin
                     d.state = rxm_pkg::ST_PIN_DATA;
                  end
               end
               rxm_pkg::ST_PIN_DATA: begin
                  if (!strobe_high) begin
                     d.state = rxm_pkg::ST_PIN_DRAIN;
                  end else if (q.eom_seen && !sif.busy && !load) begin
                     d.state = rxm_pkg::ST_PIN_RAW;
                  end
               end
               rxm_pkg::ST_PIN_DRAIN: begin
                  if (!sif.busy) begin
                     d.state = rxm_pkg::ST_SLEEP_ENT;
                  end
               end
               rxm_pkg::ST_PIN_RAW: begin
                  if (!strobe_high) begin
                     d.state = rxm_pkg::ST_SLEEP_ENT;
                  end
               end
               default: begin
                  d.state = rxm_pkg::ST_POR;
               end
            endcase
         end
      end

      // Per-state bookkeeping on entry.
      leave = (d.state != q.state);
      if (leave) begin
         d.strobe_seen  = strobe_tick;
         d.id_seen      = match_found;
         d.hdr_seen     = header_found;
         d.hdr_inv      = header_found & header_inverted;
         d.eom_seen     = end_of_message;
         d.wake_cnt     = 5'h00;
         d.tmo_cnt      = 7'h00;
         d.byte_pending = (d.state == rxm_pkg::ST_PIN_ID) ||
                          (d.state == rxm_pkg::ST_OSC_DUMMY);
         if (d.state == rxm_pkg::ST_OSC_DATA || d.state == rxm_pkg::ST_PIN_DATA) begin
            d.invert = he_eff & q.hdr_inv;
         end
      end

      // Pin drive: slave in configuration, raw data without the data manager.
      if (q.state == rxm_pkg::ST_CONFIG || q.state == rxm_pkg::ST_POR) begin
         d.mosi_oe = 1'b0;
         d.sclk_oe = 1'b0;
         d.mosi    = 1'b0;
         d.sclk    = 1'b0;
      end else if (!data_manager_enable) begin
         d.mosi_oe = 1'b1;
         d.sclk_oe = 1'b0;
         d.mosi    = receiver_on & demod_raw;
         d.sclk    = 1'b0;
      end else if (q.state == rxm_pkg::ST_PIN_RAW) begin
         d.mosi_oe = 1'b1;
         d.sclk_oe = 1'b1;
         d.mosi    = demod_raw;
         d.sclk    = 1'b0;
      end else begin
         d.mosi_oe = 1'b1;
         d.sclk_oe = 1'b1;
         d.mosi    = sif.sdo;
         d.sclk    = sif.sclk;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q       <= '0;
         q.state <= rxm_pkg::ST_POR;
         q.cfg   <= `RXM_CFG_RESET;
      end else begin
         q <= d;
      end
   end

   always_comb begin
      state_code      = q.state;
      receiver_on     = (q.state != rxm_pkg::ST_OSC_SLEEP) &&
                        (q.state != rxm_pkg::ST_PIN_SLEEP);
      strobe_osc_on   = q.cfg[`RXM_CFG_SOE_BIT];
      osc_pulldown_en = ~strobe_at_supply;
      spi_slave_mode  = (q.state == rxm_pkg::ST_CONFIG);
      config_regs     = q.cfg;
      demod_data_pin  = receiver_on & demod_raw;
      mosi_o          = q.mosi;
      mosi_oe         = q.mosi_oe;
      sclk_o          = q.sclk;
      sclk_oe         = q.sclk_oe;
   end
endmodule

// ===== bench/rxm_seq_props.sv
`timescale 1ns/1ps
module rxm_seq_props (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // Controller side
   input wire logic        config_hold_n,
   input wire logic        strobe_at_supply,
   input wire logic        demod_raw,
   // Device outputs
   input wire logic [3:0]  state_code,
   input wire logic        receiver_on,
   input wire logic        strobe_osc_on,
   input wire logic        osc_pulldown_en,
   input wire logic        spi_slave_mode,
   input wire logic [23:0] config_regs,
   input wire logic        demod_data_pin,
   input wire logic        mosi_oe,
   input wire logic        sclk_o,
   input wire logic        sclk_oe
);
   logic [7:0] ts_q;
   logic [8:0] low_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Mirrors the sample tick phase and counts how long hold has been low.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ts_q  <= 8'h00;
         low_q <= 9'h000;
      end else begin
         ts_q  <= (ts_q == 8'h9f) ? 8'h00 : ts_q + 8'h01;
         low_q <= config_hold_n ? 9'h000 : (low_q == 9'h1ff ? low_q : low_q + 9'h001);
      end
   end
   sequence s_left_config;
      $past(state_code) == rxm_pkg::ST_CONFIG && state_code != rxm_pkg::ST_CONFIG;
   endsequence
   sequence s_asleep;
      state_code == rxm_pkg::ST_OSC_SLEEP || state_code == rxm_pkg::ST_PIN_SLEEP;
   endsequence
   AST_SLEEP_RX_OFF: assert property (s_asleep |-> !receiver_on)
      else $error("receiver on while asleep");
   AST_OSC_SLEEP_ON: assert property (state_code == rxm_pkg::ST_OSC_SLEEP |-> strobe_osc_on)
      else $error("strobe oscillator off in oscillator sleep");
   AST_CFG_SLAVE: assert property (state_code == rxm_pkg::ST_CONFIG
      |-> spi_slave_mode && receiver_on && demod_data_pin == demod_raw)
      else $error("configuration mode outputs wrong");
   AST_CFG_NO_DRIVE: assert property (state_code == rxm_pkg::ST_CONFIG
      && $past(state_code) == rxm_pkg::ST_CONFIG |-> !mosi_oe && !sclk_oe)
      else $error("master pins driven in configuration");
   AST_TICK_ALIGN: assert property ($changed(state_code) |-> ts_q == 8'h00)
      else $error("state moved off the sample tick");
   AST_CFG_TO_SLEEP: assert property (s_left_config |-> ##[1:479] s_asleep)
      else $error("configuration to sleep too slow");
   AST_HOLD_FORCE: assert property (low_q >= 9'h14a |-> state_code == rxm_pkg::ST_CONFIG)
      else $error("hold low did not force configuration");
   AST_CFG_STABLE: assert property (state_code != rxm_pkg::ST_CONFIG |=> $stable(config_regs))
      else $error("configuration changed outside configuration");
   AST_PULLDOWN: assert property (osc_pulldown_en == !strobe_at_supply)
      else $error("pull-down not tied to supply detection");
   AST_RAW_NO_CLK: assert property (state_code == rxm_pkg::ST_PIN_RAW
      && $past(state_code) == rxm_pkg::ST_PIN_RAW |-> !sclk_o)
      else $error("clock driven during raw output");
endmodule

bind rxm_seq rxm_seq_props chk_u (
   .clk(clk), .rst(rst), .config_hold_n(config_hold_n), .strobe_at_supply(strobe_at_supply),
   .demod_raw(demod_raw), .state_code(state_code), .receiver_on(receiver_on),
   .strobe_osc_on(strobe_osc_on), .osc_pulldown_en(osc_pulldown_en),
   .spi_slave_mode(spi_slave_mode), .config_regs(config_regs),
   .demod_data_pin(demod_data_pin), .mosi_oe(mosi_oe), .sclk_o(sclk_o), .sclk_oe(sclk_oe)
);

// ===== bench/rxm_mcu_model.sv
`timescale 1ns/1ps
// Controller acting as SPI slave: takes the data line on each falling clock edge.
module rxm_mcu_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Wire levels at the pins
   input  wire logic       sclk,
   input  wire logic       mosi,
   // Received bytes
   output logic [7:0]      rx_byte,
   output logic [7:0]      rx_count
);
   logic       sclk_q;
   logic [7:0] sr_q;
   logic [2:0] bits_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sclk_q   <= 1'b0;
         sr_q     <= 8'h00;
         bits_q   <= 3'h0;
         rx_byte  <= 8'h00;
         rx_count <= 8'h00;
      end else begin
         sclk_q <= sclk;
         if (sclk_q && !sclk) begin
            sr_q   <= {sr_q[6:0], mosi};
            bits_q <= bits_q + 3'h1;
            if (bits_q == 3'h7) begin
               rx_byte  <= {sr_q[6:0], mosi};
               rx_count <= rx_count + 8'h01;
            end
         end
      end
   end
endmodule

// ===== bench/test_rxm_seq.sv
`timescale 1ns/1ps
module test_rxm_seq;
   logic clk, rst, config_hold_n, strobe_pin, strobe_at_supply, cfg_write, strobe_tick;
   logic demod_raw, match_found, header_found, header_inverted, end_of_message, data_valid;
   logic [23:0] cfg_data, config_regs;
   logic [7:0]  data_byte, rx_byte, rx_count;
   logic [3:0]  state_code;
   logic receiver_on, strobe_osc_on, osc_pulldown_en, spi_slave_mode, demod_data_pin;
   logic mosi_o, mosi_oe, sclk_o, sclk_oe;
   int   failures, cmp_count, cyc, n;
   // Released lines fall to the idle low level.
   wire  mosi_w = mosi_oe & mosi_o;
   wire  sclk_w = sclk_oe & sclk_o;

   rxm_seq dut_u (
      .clk(clk), .rst(rst), .config_hold_n(config_hold_n), .strobe_pin(strobe_pin),
      .strobe_at_supply(strobe_at_supply), .cfg_write(cfg_write), .cfg_data(cfg_data),
      .strobe_tick(strobe_tick), .demod_raw(demod_raw), .match_found(match_found),
      .header_found(header_found), .header_inverted(header_inverted),
      .end_of_message(end_of_message), .data_valid(data_valid), .data_byte(data_byte),
      .state_code(state_code), .receiver_on(receiver_on), .strobe_osc_on(strobe_osc_on),
      .osc_pulldown_en(osc_pulldown_en), .spi_slave_mode(spi_slave_mode),
      .config_regs(config_regs), .demod_data_pin(demod_data_pin), .mosi_o(mosi_o),
      .mosi_oe(mosi_oe), .sclk_o(sclk_o), .sclk_oe(sclk_oe)
   );
   rxm_mcu_model mcu_u (
      .clk(clk), .rst(rst), .sclk(sclk_w), .mosi(mosi_w), .rx_byte(rx_byte),
      .rx_count(rx_count)
   );

   task automatic complete_run();
      $display("compares %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic wait_state(input rxm_pkg::rxm_state_e st, output int k);
      k = 0;
      while (state_code !== st && k < 4000) begin
         step(1);
         k++;
      end
      check(state_code, st);
   endtask
   task automatic cfg_word(input logic [23:0] w);
      cfg_data  = w;
      cfg_write = 1'b1;
      step(1);
      cfg_write = 1'b0;
      step(2);
   endtask
   task automatic tick();
      strobe_tick = 1'b1;
      step(1);
      strobe_tick = 1'b0;
      step(9);
   endtask

   initial clk = 1'b0;
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         failures++;
         complete_run();
      end
   end

   initial begin
      {cfg_write, strobe_tick, demod_raw, match_found, header_found} = 5'h00;
      {header_inverted, end_of_message, data_valid, strobe_pin, strobe_at_supply} = 5'h00;
      cfg_data      = 24'h000000;
      data_byte     = 8'h00;
      config_hold_n = 1'b1;
      rst           = 1'b1;
      step(16);
      check(state_code, rxm_pkg::ST_POR);
      check(config_regs, 24'hd40080);
      check(mosi_oe | sclk_oe, 1'b0);
      rst = 1'b0;
      wait_state(rxm_pkg::ST_OSC_SLEEP, n);
      check({receiver_on, strobe_osc_on}, 2'h1);
      config_hold_n = 1'b0;
      wait_state(rxm_pkg::ST_CONFIG, n);
      check(n <= 330, 1'b1);
      check(spi_slave_mode & receiver_on, 1'b1);
      demod_raw = 1'b1;
      step(20);
      check(demod_data_pin, 1'b1);
      cfg_word(24'hd3a580);
      check(config_regs, 24'hd40080);
      cfg_word(24'h43a580);
      check(config_regs, 24'h43a580);
      step(400);
      check(state_code, rxm_pkg::ST_CONFIG);
      config_hold_n = 1'b1;
      wait_state(rxm_pkg::ST_PIN_SLEEP, n);
      check(n < 480, 1'b1);
      strobe_pin = 1'b1;
      wait_state(rxm_pkg::ST_PIN_RUN, n);
      step(400);
      check(state_code, rxm_pkg::ST_PIN_RUN);
      match_found = 1'b1;
      step(1);
      match_found = 1'b0;
      wait_state(rxm_pkg::ST_PIN_ID, n);
      wait_state(rxm_pkg::ST_PIN_HDR, n);
      check(n >= 2576 && n < 3056, 1'b1);
      check({rx_count, rx_byte}, 16'h01a5);
      {header_found, header_inverted} = 2'h3;
      step(1);
      {header_found, header_inverted} = 2'h0;
      wait_state(rxm_pkg::ST_PIN_DATA, n);
      data_valid = 1'b1;
      data_byte  = 8'h3c;
      step(1);
      data_valid = 1'b0;
      for (n = 0; n < 4000 && rx_count != 8'h02; n++) step(1);
      check(rx_byte, 8'hc3);
      end_of_message = 1'b1;
      step(1);
      end_of_message = 1'b0;
      wait_state(rxm_pkg::ST_PIN_RAW, n);
      for (int v = 0; v < 2; v++) begin
         demod_raw = v[0];
         step(3);
         check({sclk_w, mosi_w}, {1'b0, v[0]});
      end
      strobe_pin = 1'b0;
      wait_state(rxm_pkg::ST_PIN_SLEEP, n);
      check(n <= 481, 1'b1);
      strobe_at_supply = 1'b1;
      step(1);
      check(osc_pulldown_en, 1'b0);
      wait_state(rxm_pkg::ST_PIN_RUN, n);
      config_hold_n = 1'b0;
      wait_state(rxm_pkg::ST_CONFIG, n);
      strobe_at_supply = 1'b0;
      cfg_word(24'h53a580);
      config_hold_n = 1'b1;
      wait_state(rxm_pkg::ST_OSC_SLEEP, n);
      for (int k = 0; k < 2; k++) begin
         repeat (2) tick();
         step(400);
         check(state_code, rxm_pkg::ST_OSC_SLEEP);
         tick();
         wait_state(rxm_pkg::ST_OSC_RUN, n);
         if (k == 0) begin
            tick();
            wait_state(rxm_pkg::ST_OSC_SLEEP, n);
         end
      end
      match_found = 1'b1;
      step(1);
      match_found = 1'b0;
      wait_state(rxm_pkg::ST_OSC_HDR, n);
      repeat (65) tick();
      step(400);
      check(state_code, rxm_pkg::ST_OSC_HDR);
      tick();
      wait_state(rxm_pkg::ST_OSC_SLEEP, n);
      strobe_pin = 1'b1;
      wait_state(rxm_pkg::ST_OSC_RUN, n);
      strobe_pin = 1'b0;
      match_found = 1'b1;
      step(1);
      match_found = 1'b0;
      wait_state(rxm_pkg::ST_OSC_HDR, n);
      header_found = 1'b1;
      step(1);
      header_found = 1'b0;
      wait_state(rxm_pkg::ST_OSC_DATA, n);
      data_valid = 1'b1;
      data_byte  = 8'h5a;
      step(1);
      data_valid = 1'b0;
      for (n = 0; n < 4000 && rx_count != 8'h03; n++) step(1);
      check(rx_byte, 8'h5a);
      end_of_message = 1'b1;
      step(1);
      end_of_message = 1'b0;
      wait_state(rxm_pkg::ST_OSC_SLEEP, n);
      check({rx_count, rx_byte}, 16'h0400);
      complete_run();
   end
endmodule
